/* File: verilog/trap_consts.svh */
`ifndef TRAP_CONSTS_SVH
`define TRAP_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_CLEAR 5'h08
`define REG_ENABLE 5'h0C
`define REG_PENDING 5'h10
`define REG_VECTOR 5'h14

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define CTRL_RESET 2'h3
`define CTRL_GRANT_EN 0
`define CTRL_TIMEOUT_EN 1
`define ENABLE_RESET 6'h00
`define EVT_W 6

// ----------------------------------------
// pending slots, highest priority first
// ----------------------------------------
`define SLOT_W 14
`define SLOT_HALT_INSTR 4'h0
`define SLOT_ODD 4'h1
`define SLOT_MMU 4'h2
`define SLOT_TIMEOUT 4'h3
`define SLOT_PARITY 4'h4
`define SLOT_INSTR 4'h5
`define SLOT_TRACE 4'h6
`define SLOT_STOV 4'h7
`define SLOT_PFAIL 4'h8
`define SLOT_CONSOLE 4'h9
`define SLOT_REQ7 4'hA

// ----------------------------------------
// instruction trap codes
// ----------------------------------------
`define CODE_NONE 3'h0
`define CODE_ILLEGAL 3'h1
`define CODE_BREAK 3'h2
`define CODE_IO 3'h3
`define CODE_EMUL 3'h4
`define CODE_TRAP 3'h5
`define CODE_HALT 3'h6

// ----------------------------------------
// vectors (octal 004..250 as hex)
// ----------------------------------------
`define VEC_BUS_ERR 16'h0004
`define VEC_ILLEGAL 16'h0008
`define VEC_BREAK 16'h000C
`define VEC_IO 16'h0010
`define VEC_PFAIL 16'h0014
`define VEC_EMUL 16'h0018
`define VEC_TRAP 16'h001C
`define VEC_PARITY 16'h004C
`define VEC_MMU 16'h00A8
`define VEC_NONE 16'h0000
`define PSW_OFFSET 16'h0002
`define STACK_LIMIT 16'h0100

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define TIMEOUT_NS 22000
`define TIMEOUT_CYC (`TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

/* File: verilog/trap_pkg.sv */
`default_nettype none
package trap_pkg;
   // stack and vector fetch sequence, gray from idle to PSW load; the return to idle flips two bits
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h0,
      SEQ_PUSH_PSW = 3'h1,
      SEQ_PUSH_PC = 3'h3,
      SEQ_LOAD_PC = 3'h2,
      SEQ_LOAD_PSW = 3'h6
   } seq_state_t;
   typedef logic [15:0] word_t;
endpackage
`default_nettype wire

/* File: verilog/trap_arb_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface trap_arb_if;
   logic [13:0] pending;
   logic [2:0] psw_priority;
   logic [2:0] instr_code;
   logic any;
   logic [3:0] win_idx;
   trap_pkg::word_t win_vec;
   modport arbiter (input pending, psw_priority, instr_code, output any, win_idx, win_vec);
   modport core (output pending, psw_priority, instr_code, input any, win_idx, win_vec);
endinterface
`default_nettype wire

/* File: verilog/trap_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "trap_consts.svh"
module trap_arbiter (
   trap_arb_if.arbiter arb
);
   logic [13:0] eligible;

   // bus requests only beat a lower processor priority
   genvar g;
   generate
      for (g = 0; g < `SLOT_W; g = g + 1) begin : g_elig
         if (g >= 10) begin : g_br
            assign eligible[g] = arb.pending[g] && (3'(17 - g) > arb.psw_priority);
         end else begin : g_trap
            assign eligible[g] = arb.pending[g];
         end
      end
   endgenerate

   // fixed priority pick, lowest slot wins
   always_comb begin
      arb.any = 1'b0;
      arb.win_idx = 4'h0;
      for (int i = `SLOT_W - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            arb.any = 1'b1;
            arb.win_idx = 4'(i);
         end
      end
   end

   // vector per condition; odd, timeout and overflow share VEC_BUS_ERR, trace uses VEC_BREAK
   always_comb begin
      arb.win_vec = `VEC_NONE;
      case (arb.win_idx)
         `SLOT_ODD, `SLOT_TIMEOUT, `SLOT_STOV: arb.win_vec = `VEC_BUS_ERR;
         `SLOT_MMU: arb.win_vec = `VEC_MMU;
         `SLOT_PARITY: arb.win_vec = `VEC_PARITY;
         `SLOT_TRACE: arb.win_vec = `VEC_BREAK;
         `SLOT_PFAIL: arb.win_vec = `VEC_PFAIL;
         `SLOT_INSTR: begin
            case (arb.instr_code)
               `CODE_ILLEGAL: arb.win_vec = `VEC_ILLEGAL;
               `CODE_BREAK: arb.win_vec = `VEC_BREAK;
               `CODE_IO: arb.win_vec = `VEC_IO;
               `CODE_EMUL: arb.win_vec = `VEC_EMUL;
               `CODE_TRAP: arb.win_vec = `VEC_TRAP;
               default: arb.win_vec = `VEC_NONE;
            endcase
         end
         default: arb.win_vec = `VEC_NONE;
      endcase
   end
endmodule
`default_nettype wire

/* File: verilog/trap_service_vectoring.sv */
// Function
// - each serviced trap condition gets a vector address; bus errors and stack overflow share 004.
// - after service, push PC and PROCESSOR_STATUS_WORD, then load PC from vector.
// - then load PROCESSOR_STATUS_WORD from the word after the vector.
// - nonexistent memory, odd address or 22 us reply timeout raise bus error.
// - kernel stack pointer below 400 octal sets overflow next clock; user exempt.
// - instruction traps arrive as an encoded trap code from decode.
// - pending trap on service entry asserts the microprogram branch bit.
// - during service, drive vector on ALU mux and select that path.
// - 004 bus errors and stack overflow, 014 breakpoint, 024 power fail.
// - 010 illegal/reserved, 020 io trap, 030 emulator trap.
// - 034 trap instruction, 114 parity, 250 memory management.
// - clear the serviced condition, pulsing overflow or power fail clears.
// - service OR processor initialize clears the instruction register; service clears it here only when the instruction trap slot won.
// - device interrupt forces branch only with no higher trap pending.
// - service state blocks bus grants.
// - fixed priority from halt instruction down to bus request 4.
// - everything pending is arbitrated together on service entry.
// - device vector latched into operand register, slave sync returned.
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "trap_consts.svh"
module trap_service_vectoring (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   input wire logic service_state_i,
   input wire logic processor_initialize_i,
   input wire logic [2:0] instruction_trap_code_i,
   input wire logic odd_address_i,
   input wire logic nonexistent_memory_i,
   input wire logic mmu_error_i,
   input wire logic parity_error_i,
   input wire logic trace_bit_i,
   input wire logic bus_cycle_i,
   input wire logic sp_decrement_i,
   input wire logic kernel_mode_i,
   input wire logic [15:0] sp_next_value_i,
   input wire logic [2:0] psw_priority_i,
   input wire logic mem_done_i,
   input wire logic slave_sync_reply_i,
   input wire logic power_fail_i,
   input wire logic console_halt_i,
   input wire logic [3:0] bus_request_i,
   input wire logic device_interrupt_line_i,
   input wire logic [15:0] data_lines_i,
   output logic microprogram_branch_bit_o,
   output logic vector_code_bit_a_o,
   output logic vector_code_bit_b_o,
   output logic vector_code_bit_c_o,
   output logic [15:0] alu_output_mux_o,
   output logic alu_mux_select_o,
   output logic stack_overflow_clear_o,
   output logic power_fail_clear_o,
   output logic instruction_register_clear_o,
   output logic [3:0] bus_grant_o,
   output logic halt_grant_o,
   output logic slave_sync_o,
   output logic [15:0] operand_vector_o,
   output logic [2:0] seq_step_o,
   output logic mem_write_o,
   output logic [15:0] mem_addr_o
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [7:0] pin_meta;
   logic [7:0] pin_sync;
   logic ssyn_s, pfail_s, console_s, intr_s, intr_q;
   logic [3:0] req_s;

   // two flops per asynchronous pin
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         pin_meta <= {bus_request_i, device_interrupt_line_i, console_halt_i,
                      power_fail_i, slave_sync_reply_i};
         pin_sync <= pin_meta;
      end
   end
   assign ssyn_s = pin_sync[0];
   assign pfail_s = pin_sync[1];
   assign console_s = pin_sync[2];
   assign intr_s = pin_sync[3];
   assign req_s = pin_sync[7:4];

   // ----------------------------------------
   // service entry and exit detection
   // ----------------------------------------
   logic serv_q, serv_entry, serv_exit;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         serv_q <= 1'b0;
         intr_q <= 1'b0;
      end else begin
         serv_q <= service_state_i;
         intr_q <= intr_s;
      end
   end
   assign serv_entry = service_state_i && !serv_q;
   assign serv_exit = !service_state_i && serv_q;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [1:0] ctrl;
   logic [5:0] evt_status, evt_enable, evt_set, evt_clr;
   logic [31:0] bmask;
   logic bus_ack, wr_hit, rd_hit;

   // ----------------------------------------
   // bus error detection
   // ----------------------------------------
   logic [11:0] timeout_cnt;
   logic timeout_hit;

   // reply timer restarts each bus cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !bus_cycle_i || ssyn_s) begin
         timeout_cnt <= 12'h000;
      end else if (timeout_cnt != 12'(`TIMEOUT_CYC)) begin
         timeout_cnt <= timeout_cnt + 12'h001;
      end
   end
   assign timeout_hit = ctrl[`CTRL_TIMEOUT_EN] && bus_cycle_i && !ssyn_s &&
                        (timeout_cnt == 12'(`TIMEOUT_CYC - 1));

   // ----------------------------------------
   // pending trap flags
   // ----------------------------------------
   logic odd_f, mmu_f, tmo_f, par_f, stov_f, pfail_f, stov_set;
   logic win_take, pfail_q, arb_won;
   logic [3:0] win_idx_q;
   trap_arb_if arb ();

   assign stov_set = sp_decrement_i && kernel_mode_i && (sp_next_value_i < `STACK_LIMIT);
   assign win_take = serv_q && service_state_i && !serv_entry;

   // sticky flags, a new event wins over the clear
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         odd_f <= 1'b0;
         mmu_f <= 1'b0;
         tmo_f <= 1'b0;
         par_f <= 1'b0;
         stov_f <= 1'b0;
         pfail_f <= 1'b0;
      end else begin
         if (serv_exit && arb_won) begin
            case (win_idx_q)
               `SLOT_ODD: odd_f <= 1'b0;
               `SLOT_MMU: mmu_f <= 1'b0;
               `SLOT_TIMEOUT: tmo_f <= 1'b0;
               `SLOT_PARITY: par_f <= 1'b0;
               `SLOT_STOV: stov_f <= 1'b0;
               `SLOT_PFAIL: pfail_f <= 1'b0;
               default: ;
            endcase
         end
         if (odd_address_i) odd_f <= 1'b1;
         if (nonexistent_memory_i || timeout_hit) tmo_f <= 1'b1;
         if (mmu_error_i) mmu_f <= 1'b1;
         if (parity_error_i) par_f <= 1'b1;
         if (stov_set) stov_f <= 1'b1;
         if (pfail_s && !pfail_q) pfail_f <= 1'b1;
      end
   end

   // ----------------------------------------
   // arbitration on service entry
   // ----------------------------------------
   logic [3:0] req_latched, req_now;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pfail_q <= 1'b0;
         req_latched <= 4'h0;
      end else begin
         pfail_q <= pfail_s;
         if (serv_entry) req_latched <= req_s;
      end
   end

   // requests seen on the entry cycle join that same arbitration
   assign req_now = serv_entry ? req_s : req_latched;
   assign arb.pending = {req_now[0], req_now[1], req_now[2], req_now[3],
                         console_s, pfail_f, stov_f, trace_bit_i,
                         (instruction_trap_code_i != `CODE_NONE) &&
                         (instruction_trap_code_i != `CODE_HALT),
                         par_f, tmo_f, mmu_f, odd_f,
                         instruction_trap_code_i == `CODE_HALT};
   assign arb.psw_priority = psw_priority_i;
   assign arb.instr_code = instruction_trap_code_i;

   trap_arbiter u_arbiter (
      .arb(arb)
   );

   // latch the winner on the first service cycle
   logic [15:0] vec_q;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         arb_won <= 1'b0;
         win_idx_q <= 4'h0;
         vec_q <= `VEC_NONE;
      end else if (serv_entry) begin
         arb_won <= arb.any;
         win_idx_q <= arb.win_idx;
         vec_q <= (arb.win_idx >= `SLOT_REQ7) ? operand_vector_o : arb.win_vec;
      end
   end

   logic is_halt, is_br, branch;
   assign is_halt = (win_idx_q == `SLOT_HALT_INSTR) || (win_idx_q == `SLOT_CONSOLE);
   assign is_br = win_idx_q >= `SLOT_REQ7;
   // device interrupt branches only when it truly won
   assign branch = arb_won && !is_halt && (!is_br || intr_s);

   // ----------------------------------------
   // service outputs
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         microprogram_branch_bit_o <= 1'b0;
         alu_mux_select_o <= 1'b0;
         alu_output_mux_o <= `VEC_NONE;
         halt_grant_o <= 1'b0;
      end else begin
         microprogram_branch_bit_o <= win_take && branch;
         alu_mux_select_o <= win_take && branch;
         alu_output_mux_o <= (win_take && branch) ? vec_q : `VEC_NONE;
         halt_grant_o <= win_take && arb_won && is_halt;
      end
   end
   assign vector_code_bit_a_o = alu_output_mux_o[2];
   assign vector_code_bit_b_o = alu_output_mux_o[3];
   assign vector_code_bit_c_o = alu_output_mux_o[4];

   // clear pulses one cycle after service exit is seen
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         stack_overflow_clear_o <= 1'b0;
         power_fail_clear_o <= 1'b0;
      end else begin
         stack_overflow_clear_o <= serv_exit && arb_won && (win_idx_q == `SLOT_STOV);
         power_fail_clear_o <= serv_exit && arb_won && (win_idx_q == `SLOT_PFAIL);
      end
   end
   assign instruction_register_clear_o = processor_initialize_i ||
      (service_state_i && arb_won && (win_idx_q == `SLOT_INSTR));

   // ----------------------------------------
   // bus grant and device vector
   // ----------------------------------------
   always_comb begin
      bus_grant_o = 4'h0;
      if (!service_state_i && ctrl[`CTRL_GRANT_EN] && arb_won && is_br) begin
         bus_grant_o = 4'h8 >> (win_idx_q - `SLOT_REQ7);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         operand_vector_o <= `VEC_NONE;
         slave_sync_o <= 1'b0;
      end else begin
         slave_sync_o <= intr_s && !intr_q;
         if (intr_s && !intr_q) operand_vector_o <= data_lines_i;
      end
   end

   // ----------------------------------------
   // stack push and vector fetch sequence
   // ----------------------------------------
   trap_pkg::seq_state_t seq;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         seq <= trap_pkg::SEQ_IDLE;
      end else begin
         unique case (seq)
            trap_pkg::SEQ_IDLE: if (serv_exit && arb_won && branch) seq <= trap_pkg::SEQ_PUSH_PSW;
            trap_pkg::SEQ_PUSH_PSW: if (mem_done_i) seq <= trap_pkg::SEQ_PUSH_PC;
            trap_pkg::SEQ_PUSH_PC: if (mem_done_i) seq <= trap_pkg::SEQ_LOAD_PC;
            trap_pkg::SEQ_LOAD_PC: if (mem_done_i) seq <= trap_pkg::SEQ_LOAD_PSW;
            trap_pkg::SEQ_LOAD_PSW: if (mem_done_i) seq <= trap_pkg::SEQ_IDLE;
            default: seq <= trap_pkg::SEQ_IDLE;
         endcase
      end
   end
   assign seq_step_o = seq;
   assign mem_write_o = (seq == trap_pkg::SEQ_PUSH_PSW) || (seq == trap_pkg::SEQ_PUSH_PC);
   always_comb begin
      mem_addr_o = `VEC_NONE;
      if (seq == trap_pkg::SEQ_LOAD_PC) mem_addr_o = vec_q;
      if (seq == trap_pkg::SEQ_LOAD_PSW) mem_addr_o = vec_q + `PSW_OFFSET;
   end

   // ----------------------------------------
   // avalon slave, one wait state
   // ----------------------------------------
   assign evt_set = {branch && win_take && !microprogram_branch_bit_o, pfail_s && !pfail_q,
                     stov_set, parity_error_i, mmu_error_i,
                     odd_address_i || nonexistent_memory_i || timeout_hit};
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !bus_ack;
   assign wr_hit = avs_write_i && bus_ack;
   assign rd_hit = avs_read_i && !bus_ack;
   assign bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign evt_clr = (wr_hit && avs_address_i == `REG_CLEAR) ?
                    avs_writedata_i[5:0] & bmask[5:0] : 6'h00;

   // register writes and acknowledge
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         bus_ack <= 1'b0;
         ctrl <= `CTRL_RESET;
         evt_enable <= `ENABLE_RESET;
         evt_status <= 6'h00;
      end else begin
         bus_ack <= (avs_read_i || avs_write_i) && !bus_ack;
         evt_status <= (evt_status & ~evt_clr) | evt_set;
         if (wr_hit && avs_address_i == `REG_CTRL && avs_byteenable_i[0]) ctrl <= avs_writedata_i[1:0];
         if (wr_hit && avs_address_i == `REG_ENABLE && avs_byteenable_i[0]) evt_enable <= avs_writedata_i[5:0];
      end
   end
   assign irq_o = |(evt_status & evt_enable);

   // read data registered ahead of the ack
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (rd_hit) begin
         case (avs_address_i)
            `REG_CTRL: avs_readdata_o <= {30'h0, ctrl};
            `REG_STATUS: avs_readdata_o <= {26'h0, evt_status};
            `REG_ENABLE: avs_readdata_o <= {26'h0, evt_enable};
            `REG_PENDING: avs_readdata_o <= {18'h0, arb.pending};
            `REG_VECTOR: avs_readdata_o <= {16'h0, vec_q};
            default: avs_readdata_o <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_entry_trap;
      serv_entry && arb.any && !(arb.win_idx >= `SLOT_REQ7) &&
      (arb.win_idx != `SLOT_HALT_INSTR) && (arb.win_idx != `SLOT_CONSOLE);
   endsequence
   sequence s_still_serv;
      service_state_i [*2];
   endsequence
   property p_branch;
      @(posedge core_clk_i) disable iff (rst_i)
      s_entry_trap ##0 s_still_serv |=> microprogram_branch_bit_o;
   endproperty
   a_branch: assert property (p_branch) else $error("no branch on pending trap");
   property p_mux;
      @(posedge core_clk_i) disable iff (rst_i)
      microprogram_branch_bit_o |-> alu_mux_select_o && alu_output_mux_o == vec_q;
   endproperty
   a_mux: assert property (p_mux) else $error("vector not on alu mux");
   property p_stov;
      @(posedge core_clk_i) disable iff (rst_i)
      sp_decrement_i && kernel_mode_i && sp_next_value_i == 16'h00FF |=> stov_f;
   endproperty
   a_stov: assert property (p_stov) else $error("stack overflow not set");
   property p_user_exempt;
      @(posedge core_clk_i) disable iff (rst_i)
      !stov_f && !kernel_mode_i && !(serv_exit) |=> !stov_f || $past(stov_set);
   endproperty
   a_user_exempt: assert property (p_user_exempt) else $error("user sp set overflow");
   property p_timeout;
      @(posedge core_clk_i) disable iff (rst_i)
      timeout_hit |=> tmo_f;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout flag missing");
   property p_vec_odd;
      @(posedge core_clk_i) disable iff (rst_i)
      serv_entry && arb.any && arb.win_idx == `SLOT_ODD |=> vec_q == `VEC_BUS_ERR;
   endproperty
   a_vec_odd: assert property (p_vec_odd) else $error("odd address vector wrong");
   property p_vec_io;
      @(posedge core_clk_i) disable iff (rst_i)
      serv_entry && arb.win_idx == `SLOT_INSTR && instruction_trap_code_i == `CODE_IO
      |=> vec_q == `VEC_IO;
   endproperty
   a_vec_io: assert property (p_vec_io) else $error("io trap vector wrong");
   property p_vec_mmu;
      @(posedge core_clk_i) disable iff (rst_i)
      serv_entry && arb.any && arb.win_idx == `SLOT_MMU |=> vec_q == `VEC_MMU;
   endproperty
   a_vec_mmu: assert property (p_vec_mmu) else $error("mmu vector wrong");
   property p_no_grant;
      @(posedge core_clk_i) disable iff (rst_i)
      service_state_i |-> bus_grant_o == 4'h0;
   endproperty
   a_no_grant: assert property (p_no_grant) else $error("grant during service");
   property p_irclr;
      @(posedge core_clk_i)
      processor_initialize_i |-> instruction_register_clear_o;
   endproperty
   a_irclr: assert property (p_irclr) else $error("ir not cleared on init");
   property p_seq;
      @(posedge core_clk_i) disable iff (rst_i)
      seq == trap_pkg::SEQ_LOAD_PC && mem_done_i |=> mem_addr_o == vec_q + `PSW_OFFSET;
   endproperty
   a_seq: assert property (p_seq) else $error("psw not fetched after pc");
   property p_ssyn;
      @(posedge core_clk_i) disable iff (rst_i)
      intr_s && !intr_q |=> slave_sync_o && operand_vector_o == $past(data_lines_i);
   endproperty
   a_ssyn: assert property (p_ssyn) else $error("device vector not latched");
endmodule
`default_nettype wire

/* File: dv/trap_far_side.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// far-side memory stepper
// ----------------------------------------
module trap_far_side (
   input wire logic core_clk_i,
   input wire logic [2:0] seq_step_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [1:0] lag_i,
   output logic mem_done_o,
   output logic [15:0] pc_addr_o,
   output logic [15:0] psw_addr_o
);
   logic [1:0] wait_cnt;
   // one done pulse per step, lag plus one cycles after the step starts
   always_ff @(posedge core_clk_i) begin
      mem_done_o <= 1'b0;
      wait_cnt <= 2'h0;
      if (seq_step_i != 3'h0 && mem_done_o !== 1'b1) begin
         wait_cnt <= wait_cnt + 2'h1;
         mem_done_o <= (wait_cnt == lag_i);
      end
      if (seq_step_i == 3'h2) pc_addr_o <= mem_addr_i;
      if (seq_step_i == 3'h6) psw_addr_o <= mem_addr_i;
   end
endmodule
`default_nettype wire

/* File: dv/trap_service_vectoring_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module trap_service_vectoring_tb_top;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, svc = 1'b0, kern = 1'b0;
   logic pf = 1'b0, trc = 1'b0, done, wq, irq, branch, sel, irclr, bc = 1'b0, pfc;
   logic [4:0] addr = 5'h00, ev = 5'h00;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic [2:0] code = 3'h0, pri = 3'h7, step, vc;
   logic [1:0] lag = 2'h0;
   logic [3:0] breq = 4'h0, grant;
   logic [15:0] mux, pc_a, psw_a, maddr, spv = 16'h00FF;
   logic [15:0] vt [6] = '{16'h0, 16'h0008, 16'h000C, 16'h0010, 16'h0018, 16'h001C};
   int err_total = 0, check_count = 0;
   trap_service_vectoring dut_u (.core_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wq), .irq_o(irq), .service_state_i(svc),
      .processor_initialize_i(rst), .instruction_trap_code_i(code), .odd_address_i(ev[0]),
      .nonexistent_memory_i(ev[4]), .mmu_error_i(ev[2]), .parity_error_i(ev[1]),
      .trace_bit_i(trc), .bus_cycle_i(bc), .sp_decrement_i(ev[3]), .kernel_mode_i(kern),
      .sp_next_value_i(spv), .psw_priority_i(pri), .mem_done_i(done),
      .slave_sync_reply_i(1'b0), .power_fail_i(pf), .console_halt_i(1'b0),
      .bus_request_i(breq), .device_interrupt_line_i(1'b0), .data_lines_i(16'h0),
      .microprogram_branch_bit_o(branch), .vector_code_bit_a_o(vc[0]),
      .vector_code_bit_b_o(vc[1]), .vector_code_bit_c_o(vc[2]), .alu_output_mux_o(mux),
      .alu_mux_select_o(sel), .stack_overflow_clear_o(), .power_fail_clear_o(pfc),
      .instruction_register_clear_o(irclr), .bus_grant_o(grant), .halt_grant_o(),
      .slave_sync_o(), .operand_vector_o(), .seq_step_o(step), .mem_write_o(),
      .mem_addr_o(maddr));
   trap_far_side far_u (.core_clk_i(clk), .seq_step_i(step), .mem_addr_i(maddr),
      .lag_i(lag), .mem_done_o(done), .pc_addr_o(pc_a), .psw_addr_o(psw_a));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk);
         n++;
      end while (wq !== 1'b0 && n < 20);
      if (n >= 20) begin
         err_total++;
         test_done();
      end
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic fire(input logic [4:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 5'h00;
   endtask
   task automatic serve(input logic [15:0] v);
      int n = 0;
      logic pclr = 1'b0;
      @(posedge clk);
      svc <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({branch, sel, irclr, grant, vc, mux}, {2'h3, |code, 4'h0, v[4:2], v});
      @(posedge clk);
      svc <= 1'b0;
      do begin
         @(negedge clk);
         n++;
         pclr = pclr | pfc;
      end while ((n < 3 || step !== 3'h0) && n < 40);
      if (n >= 40) begin
         err_total++;
         test_done();
      end
      chk({pc_a, psw_a}, {v, v + 16'h0002});
      chk(pclr, v == 16'h0014);
   endtask
   // clock
   initial begin
      forever #5 clk = ~clk;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 5'h00, 32'h0);
      chk(got, 32'h3);
      bus(1'b0, 5'h18, 32'h0);
      chk(got, 32'h0);
      fire(5'h03);
      serve(16'h0004);
      serve(16'h004C);
      fire(5'h04);
      serve(16'h00A8);
      fire(5'h10);
      serve(16'h0004);
      @(posedge clk);
      trc <= 1'b1;
      serve(16'h000C);
      trc <= 1'b0;
      for (int i = 1; i < 6; i++) begin
         @(posedge clk);
         code <= i[2:0];
         lag <= i[1:0];
         serve(vt[i]);
      end
      @(posedge clk);
      code <= 3'h0;
      pf <= 1'b1;
      repeat (4) @(posedge clk);
      serve(16'h0014);
      bus(1'b1, 5'h08, 32'h3F);
      fire(5'h08);
      bus(1'b0, 5'h04, 32'h0);
      chk(got[3], 1'b0);
      kern <= 1'b1;
      spv <= 16'h0100;
      fire(5'h08);
      bus(1'b0, 5'h04, 32'h0);
      chk(got[3], 1'b0);
      spv <= 16'h00FF;
      fire(5'h08);
      bus(1'b0, 5'h04, 32'h0);
      chk({got[3], irq}, 2'h2);
      bus(1'b1, 5'h0C, 32'h8);
      @(negedge clk);
      chk(irq, 1'b1);
      serve(16'h0004);
      bus(1'b1, 5'h08, 32'h8);
      @(negedge clk);
      chk(irq, 1'b0);
      @(posedge clk);
      pri <= 3'h0;
      breq <= 4'h8;
      repeat (4) @(posedge clk);
      svc <= 1'b1;
      repeat (2) @(posedge clk);
      svc <= 1'b0;
      @(negedge clk);
      chk({grant, branch}, 5'h10);
      @(posedge clk);
      svc <= 1'b1;
      @(negedge clk);
      chk(grant, 4'h0);
      @(posedge clk);
      svc <= 1'b0;
      bus(1'b1, 5'h08, 32'h3F);
      bc <= 1'b1;
      repeat (2150) @(posedge clk);
      bus(1'b0, 5'h04, 32'h0);
      chk(got[0], 1'b0);
      repeat (60) @(posedge clk);
      bc <= 1'b0;
      bus(1'b0, 5'h04, 32'h0);
      chk(got[0], 1'b1);
      test_done();
   end
endmodule
`default_nettype wire
